// ---- cpr_codec_regs.sv ----
// codec control register bank: strap-selected defaults, serial control port, frame clock tracking
//
// Summary of operation
// - power-up select high before codec reset puts the device in power-up-on-reset mode.
// - power-up-on-reset mode starts conversion on default contents, no host writes needed.
// - after reset every register is readable and writable over the serial control port.
// - select high loads power control with 0x9b at reset.
// - select low loads power control with 0xf6 instead.
// - mode 0x02, transmit gain 0x40, receive gain 0xa0, tone and auxiliary cleared.
// - default power value: reference up, earpiece amps down, paths and bias on, sidetone muted.
// - default mode: high-pass filters off, slope filter on transmit, low-pass only on receive.
// - default mode keeps the buzzer control logic off.
// - default mode selects 15-bit linear data, no companding either way.
// - default mode is normal operation, loopback off, tone mode off.
// - samples are left justified, 15 bits linear or 8 bits companded.
`timescale 1ns/10ps
module cpr_codec_regs
    import cpr_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = CPR_DEV_ADDR_DEF,
    parameter int MIN_FRAME_CYC = CPR_MIN_FRAME_CYC_DEF
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic power_up_select_pin,
    input wire logic codec_reset_cmd,
    input wire logic master_clk_in,
    input wire logic frame_sync_input,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output cpr_regs_t regs_o,
    output logic regs_ready,
    output logic power_up_mode,
    output logic conv_run,
    output logic [3:0] word_bits,
    output logic sample_stb,
    output logic [15:0] mclk_per_frame,
    output logic frame_rate_err
);

    cpr_state_t s_ff;
    cpr_state_t nxt_s;

    logic do_load;
    logic wr_en;
    logic [2:0] wr_idx;
    logic [7:0] wr_data;
    logic i2c_start;
    logic i2c_stop;
    cpr_reg_arr_t regs_view;

    function automatic cpr_regs_t defaults(input logic sel);
        cpr_regs_t r;
        r.power = sel ? CPR_POWER_DEF_SEL : CPR_POWER_DEF_ALT;
        r.mode = CPR_MODE_DEF;
        r.tx_gain = CPR_TX_GAIN_DEF;
        r.rx_gain = CPR_RX_GAIN_DEF;
        r.high_tone = CPR_HIGH_TONE_DEF;
        r.low_tone = CPR_LOW_TONE_DEF;
        r.aux = CPR_AUX_DEF;
        return r;
    endfunction

    function automatic logic [3:0] bits_for(input logic [7:0] mode);
        return (mode[CPR_MODE_COMP_LSB +: 2] == CPR_COMP_LINEAR) ? CPR_LINEAR_BITS : CPR_COMPAND_BITS;
    endfunction

    function automatic logic [7:0] read_reg(input cpr_regs_t r, input logic [7:0] idx);
        cpr_reg_arr_t a;
        a = cpr_reg_arr_t'(r);
        return (idx <= CPR_IDX_AUX) ? a[idx[2:0]] : 8'h00;
    endfunction

    always_comb begin
        cpr_reg_arr_t arr;
        logic scl_rise;
        logic scl_fall;
        logic mclk_rise;
        logic fs_rise;
        logic [7:0] rd;
        arr = cpr_reg_arr_t'(s_ff.regs);
        rd = 8'h00;
        nxt_s = s_ff;
        wr_en = 1'b0;
        wr_idx = s_ff.idx[2:0];
        wr_data = s_ff.shreg;
        scl_rise = s_ff.scl_s2 & ~s_ff.scl_q;
        scl_fall = ~s_ff.scl_s2 & s_ff.scl_q;
        mclk_rise = s_ff.mclk_s2 & ~s_ff.mclk_q;
        fs_rise = s_ff.fs_s2 & ~s_ff.fs_q;

        // two-stage synchronisers; the second stage and, except for the strap, its delayed copy for edge detection feed logic
        nxt_s.scl_s1 = scl_i;
        nxt_s.scl_s2 = s_ff.scl_s1;
        nxt_s.scl_q = s_ff.scl_s2;
        nxt_s.sda_s1 = sda_i;
        nxt_s.sda_s2 = s_ff.sda_s1;
        nxt_s.sda_q = s_ff.sda_s2;
        nxt_s.mclk_s1 = master_clk_in;
        nxt_s.mclk_s2 = s_ff.mclk_s1;
        nxt_s.mclk_q = s_ff.mclk_s2;
        nxt_s.fs_s1 = frame_sync_input;
        nxt_s.fs_s2 = s_ff.fs_s1;
        nxt_s.fs_q = s_ff.fs_s2;
        nxt_s.sel_s1 = power_up_select_pin;
        nxt_s.sel_s2 = s_ff.sel_s1;
        nxt_s.crst_s1 = codec_reset_cmd;
        nxt_s.crst_s2 = s_ff.crst_s1;
        nxt_s.crst_q = s_ff.crst_s2;

        i2c_start = s_ff.scl_s2 & s_ff.scl_q & s_ff.sda_q & ~s_ff.sda_s2;
        i2c_stop = s_ff.scl_s2 & s_ff.scl_q & ~s_ff.sda_q & s_ff.sda_s2;

        // the strap is only trusted once the synchroniser has filled after nrst
        if (s_ff.init_cnt != CPR_SYNC_FILL) begin
            nxt_s.init_cnt = s_ff.init_cnt + 2'h1;
        end
        do_load = (s_ff.init_cnt == CPR_SYNC_FILL && !s_ff.loaded) || (s_ff.crst_s2 && !s_ff.crst_q);

        // serial control port
        unique case (s_ff.st)
            CPR_ST_IDLE: begin
            end
            CPR_ST_ADDR: begin
                if (scl_rise) begin
                    nxt_s.shreg = {s_ff.shreg[6:0], s_ff.sda_s2};
                    nxt_s.bit_cnt = s_ff.bit_cnt + 4'h1;
                end else if (scl_fall && s_ff.bit_cnt == CPR_BITS_PER_BYTE) begin
                    if (s_ff.shreg[7:1] == DEV_ADDR) begin
                        nxt_s.sda_oe = 1'b1;
                        nxt_s.more = s_ff.shreg[0];
                        nxt_s.st = CPR_ST_ADDR_ACK;
                    end else begin
                        nxt_s.st = CPR_ST_IDLE;
                    end
                end
            end
            CPR_ST_ADDR_ACK: begin
                if (scl_fall) begin
                    nxt_s.bit_cnt = 4'h0;
                    if (s_ff.more) begin
                        rd = read_reg(s_ff.regs, s_ff.idx);
                        nxt_s.shreg = rd;
                        nxt_s.sda_oe = ~rd[7];
                        nxt_s.st = CPR_ST_READ;
                    end else begin
                        nxt_s.sda_oe = 1'b0;
                        nxt_s.first_byte = 1'b1;
                        nxt_s.st = CPR_ST_WRITE;
                    end
                end
            end
            CPR_ST_WRITE: begin
                if (scl_rise) begin
                    nxt_s.shreg = {s_ff.shreg[6:0], s_ff.sda_s2};
                    nxt_s.bit_cnt = s_ff.bit_cnt + 4'h1;
                end else if (scl_fall && s_ff.bit_cnt == CPR_BITS_PER_BYTE) begin
                    nxt_s.sda_oe = 1'b1;
                    nxt_s.st = CPR_ST_WRITE_ACK;
                    if (s_ff.first_byte) begin
                        nxt_s.idx = s_ff.shreg;
                        nxt_s.first_byte = 1'b0;
                    end else begin
                        // host write; indices past the bank are acked and dropped
                        wr_en = (s_ff.idx <= CPR_IDX_AUX);
                        nxt_s.idx = s_ff.idx + 8'h01;
                    end
                end
            end
            CPR_ST_WRITE_ACK: begin
                if (scl_fall) begin
                    nxt_s.sda_oe = 1'b0;
                    nxt_s.bit_cnt = 4'h0;
                    nxt_s.st = CPR_ST_WRITE;
                end
            end
            CPR_ST_READ: begin
                if (scl_rise) begin
                    nxt_s.bit_cnt = s_ff.bit_cnt + 4'h1;
                end else if (scl_fall) begin
                    if (s_ff.bit_cnt == CPR_BITS_PER_BYTE) begin
                        nxt_s.sda_oe = 1'b0;
                        nxt_s.idx = s_ff.idx + 8'h01;
                        nxt_s.st = CPR_ST_READ_ACK;
                    end else begin
                        nxt_s.shreg = {s_ff.shreg[6:0], 1'b0};
                        nxt_s.sda_oe = ~s_ff.shreg[6];
                    end
                end
            end
            CPR_ST_READ_ACK: begin
                if (scl_rise) begin
                    nxt_s.more = ~s_ff.sda_s2;
                end else if (scl_fall) begin
                    if (s_ff.more) begin
                        rd = read_reg(s_ff.regs, s_ff.idx);
                        nxt_s.shreg = rd;
                        nxt_s.sda_oe = ~rd[7];
                        nxt_s.bit_cnt = 4'h0;
                        nxt_s.st = CPR_ST_READ;
                    end else begin
                        nxt_s.st = CPR_ST_IDLE;
                    end
                end
            end
            default: begin
                nxt_s.st = CPR_ST_IDLE;
            end
        endcase

        // start and stop override any byte in flight
        if (i2c_start) begin
            nxt_s.st = CPR_ST_ADDR;
            nxt_s.bit_cnt = 4'h0;
            nxt_s.sda_oe = 1'b0;
        end else if (i2c_stop) begin
            nxt_s.st = CPR_ST_IDLE;
            nxt_s.sda_oe = 1'b0;
        end

        if (wr_en) begin
            arr[wr_idx] = wr_data;
            nxt_s.host_wrote = 1'b1;
            nxt_s.conv_run = 1'b1;
        end
        nxt_s.regs = cpr_regs_t'(arr);

        // frame tracking on the host-supplied clocks
        nxt_s.sample_stb = 1'b0;
        if (mclk_rise) begin
            nxt_s.mclk_cnt = s_ff.mclk_cnt + 16'h0001;
        end
        if (s_ff.frame_cyc != 16'hffff) begin
            nxt_s.frame_cyc = s_ff.frame_cyc + 16'h0001;
        end
        if (fs_rise) begin
            nxt_s.mclk_per_frame = s_ff.mclk_cnt;
            // a master clock edge in the frame-edge cycle belongs to the new frame
            nxt_s.mclk_cnt = {15'h0000, mclk_rise};
            nxt_s.frame_cyc = 16'h0000;
            nxt_s.frame_seen = 1'b1;
            nxt_s.sample_stb = s_ff.conv_run;
            // a frame at or faster than the 8 kHz limit is flagged, sticky until the next codec reset
            if (s_ff.frame_seen && s_ff.frame_cyc < 16'(MIN_FRAME_CYC)) begin
                nxt_s.rate_err = 1'b1;
            end
        end

        // reload wins over writes and aborts the port
        if (do_load) begin
            nxt_s.regs = defaults(s_ff.sel_s2);
            nxt_s.loaded = 1'b1;
            nxt_s.power_up_mode = s_ff.sel_s2;
            nxt_s.conv_run = s_ff.sel_s2;
            nxt_s.host_wrote = 1'b0;
            // a fast frame seen in the load cycle itself is not lost
            nxt_s.rate_err = fs_rise && s_ff.frame_seen && s_ff.frame_cyc < 16'(MIN_FRAME_CYC);
            nxt_s.st = CPR_ST_IDLE;
            nxt_s.sda_oe = 1'b0;
            nxt_s.idx = 8'h00;
        end
        // justified width follows the companding field
        nxt_s.word_bits = bits_for(nxt_s.regs.mode);
        nxt_s.sda_out = 1'b0;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_ff <= '0;
            s_ff.st <= CPR_ST_IDLE;
            s_ff.regs <= {CPR_AUX_DEF, CPR_LOW_TONE_DEF, CPR_HIGH_TONE_DEF, CPR_RX_GAIN_DEF, CPR_TX_GAIN_DEF,
                CPR_MODE_DEF, CPR_POWER_DEF_SEL};
            s_ff.word_bits <= CPR_LINEAR_BITS;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign sda_o = s_ff.sda_out;
    assign sda_oe = s_ff.sda_oe;
    assign regs_o = s_ff.regs;
    assign regs_ready = s_ff.loaded;
    assign power_up_mode = s_ff.power_up_mode;
    assign conv_run = s_ff.conv_run;
    assign word_bits = s_ff.word_bits;
    assign sample_stb = s_ff.sample_stb;
    assign mclk_per_frame = s_ff.mclk_per_frame;
    assign frame_rate_err = s_ff.rate_err;
    assign regs_view = cpr_reg_arr_t'(s_ff.regs);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_power_sel_high: assert property (do_load && s_ff.sel_s2 |=> regs_o.power == 8'h9b)
        else $error("power control default wrong with select high");
    a_power_sel_low: assert property (do_load && !s_ff.sel_s2 |=> regs_o.power == 8'hf6)
        else $error("power control default wrong with select low");
    a_other_defaults: assert property (do_load |=> regs_o.mode == 8'h02 && regs_o.tx_gain == 8'h40
        && regs_o.rx_gain == 8'ha0 && regs_o.high_tone == 8'h00 && regs_o.low_tone == 8'h00 && regs_o.aux == 8'h00)
        else $error("reset defaults not loaded");
    a_default_linear: assert property (do_load |=> word_bits == 4'hf ##1 word_bits == 4'hf || $past(wr_en))
        else $error("default mode not 15-bit linear");
    a_mode_latched: assert property (do_load |=> power_up_mode == $past(s_ff.sel_s2) && regs_ready)
        else $error("power-up mode not taken from strap");
    a_conv_on_defaults: assert property (do_load && s_ff.sel_s2 |=> conv_run ##1 conv_run || $past(do_load))
        else $error("conversion not started on defaults");
    a_regs_hold: assert property (!do_load && !wr_en |=> $stable(regs_o))
        else $error("registers changed without write or reload");
    a_write_lands: assert property (wr_en && !do_load |=> regs_view[$past(wr_idx)] == $past(wr_data))
        else $error("host write not stored");
    a_reload_aborts: assert property (do_load |=> !sda_oe && s_ff.st == CPR_ST_IDLE)
        else $error("reload did not abort the control port");
    a_stop_release: assert property (i2c_stop && !do_load |=> !sda_oe)
        else $error("data line held after stop");

    c_load_sel_high: cover property (do_load && s_ff.sel_s2);
    c_host_write: cover property (wr_en);
    c_host_read: cover property (s_ff.st == CPR_ST_READ_ACK ##1 s_ff.st == CPR_ST_READ_ACK);
    c_frame_strobe: cover property (sample_stb ##[1:1000] sample_stb);

endmodule

// ---- cpr_pkg.sv ----
// constants, carriers and state types for the codec power-up register bank
package cpr_pkg;

    localparam int CPR_NUM_REGS = 7;

    // register indices as seen over the serial control port
    localparam logic [7:0] CPR_IDX_POWER = 8'h00;
    localparam logic [7:0] CPR_IDX_MODE = 8'h01;
    localparam logic [7:0] CPR_IDX_TX_GAIN = 8'h02;
    localparam logic [7:0] CPR_IDX_RX_GAIN = 8'h03;
    localparam logic [7:0] CPR_IDX_HIGH_TONE = 8'h04;
    localparam logic [7:0] CPR_IDX_LOW_TONE = 8'h05;
    localparam logic [7:0] CPR_IDX_AUX = 8'h06;

    // reset contents
    localparam logic [7:0] CPR_POWER_DEF_SEL = 8'h9b;
    localparam logic [7:0] CPR_POWER_DEF_ALT = 8'hf6;
    localparam logic [7:0] CPR_MODE_DEF = 8'h02;
    localparam logic [7:0] CPR_TX_GAIN_DEF = 8'h40;
    localparam logic [7:0] CPR_RX_GAIN_DEF = 8'ha0;
    localparam logic [7:0] CPR_HIGH_TONE_DEF = 8'h00;
    localparam logic [7:0] CPR_LOW_TONE_DEF = 8'h00;
    localparam logic [7:0] CPR_AUX_DEF = 8'h00;

    // companding field inside mode control
    localparam int CPR_MODE_COMP_LSB = 3;
    localparam logic [1:0] CPR_COMP_LINEAR = 2'h0;
    localparam logic [3:0] CPR_LINEAR_BITS = 4'hf;
    localparam logic [3:0] CPR_COMPAND_BITS = 4'h8;

    // serial control port
    localparam logic [6:0] CPR_DEV_ADDR_DEF = 7'h2a;   // arbitrary value
    localparam logic [3:0] CPR_BITS_PER_BYTE = 4'h8;
    localparam logic [1:0] CPR_SYNC_FILL = 2'h3;

    // frame timing: legal frames are slower than 8 kHz
    localparam int CPR_CLK_PERIOD_NS = 4;
    localparam int CPR_MIN_FRAME_NS = 125000;
    localparam int CPR_MIN_FRAME_CYC_DEF = (CPR_MIN_FRAME_NS + CPR_CLK_PERIOD_NS - 1) / CPR_CLK_PERIOD_NS;

    typedef struct packed {
        logic [7:0] aux;
        logic [7:0] low_tone;
        logic [7:0] high_tone;
        logic [7:0] rx_gain;
        logic [7:0] tx_gain;
        logic [7:0] mode;
        logic [7:0] power;
    } cpr_regs_t;

    typedef logic [CPR_NUM_REGS-1:0][7:0] cpr_reg_arr_t;

    typedef enum logic [2:0] {
        CPR_ST_IDLE = 3'h0,
        CPR_ST_ADDR = 3'h1,
        CPR_ST_ADDR_ACK = 3'h2,
        CPR_ST_WRITE = 3'h3,
        CPR_ST_WRITE_ACK = 3'h4,
        CPR_ST_READ = 3'h5,
        CPR_ST_READ_ACK = 3'h6
    } cpr_i2c_st_t;

    typedef struct packed {
        logic scl_s1, scl_s2, scl_q;
        logic sda_s1, sda_s2, sda_q;
        logic mclk_s1, mclk_s2, mclk_q;
        logic fs_s1, fs_s2, fs_q;
        logic sel_s1, sel_s2;
        logic crst_s1, crst_s2, crst_q;
        logic [1:0] init_cnt;
        logic loaded;
        logic power_up_mode;
        logic host_wrote;
        logic conv_run;
        cpr_regs_t regs;
        logic [3:0] word_bits;
        cpr_i2c_st_t st;
        logic [3:0] bit_cnt;
        logic [7:0] shreg;
        logic [7:0] idx;
        logic first_byte;
        logic more;
        logic sda_out;
        logic sda_oe;
        logic [15:0] mclk_cnt;
        logic [15:0] mclk_per_frame;
        logic [15:0] frame_cyc;
        logic frame_seen;
        logic sample_stb;
        logic rate_err;
    } cpr_state_t;

endpackage

// ---- cpr_host_model.sv ----
// host-side model: serial control port controller plus master clock and frame sync source
`timescale 1ns/10ps
module cpr_host_model
    import cpr_pkg::*;
(
    input wire logic clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_low,
    output logic mclk,
    output logic fs
);
    int fs_per = 0;

    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
        mclk = 1'b0;
        fs = 1'b0;
    end

    // master clock supply
    // free running, phase unrelated to clk
    initial begin
        #3.3;
        forever #80 mclk = ~mclk;
    end

    // frame sync supply
    // period is fs_per clk cycles; zero stops the frames
    always begin
        @(posedge clk);
        if (fs_per > 9) begin
            #1 fs = 1'b1;
            repeat (8) @(posedge clk);
            #1 fs = 1'b0;
            repeat (fs_per - 9) @(posedge clk);
        end
    end

    // five cycles keeps data changes well away from clock edges
    task automatic half();
        repeat (5) @(posedge clk);
        #1;
    endtask

    task automatic bit_io(input logic b, output logic s);
        half();
        sda_low = ~b;
        half();
        scl = 1'b1;
        half();
        s = sda_line;
        half();
        scl = 1'b0;
    endtask

    // also serves as repeated start when the clock line is low
    task automatic start();
        half();
        sda_low = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda_low = 1'b1;
        half();
        scl = 1'b0;
    endtask

    task automatic stop();
        half();
        sda_low = 1'b1;
        half();
        scl = 1'b1;
        half();
        sda_low = 1'b0;
        half();
    endtask

    task automatic send8(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = ~s;
    endtask

    task automatic wr_regs(input logic [6:0] addr, input logic [7:0] idx, input logic [7:0] q[$], output logic ack);
        logic a;
        start();
        send8({addr, 1'b0}, ack);
        send8(idx, a);
        ack = ack & a;
        foreach (q[i]) begin
            send8(q[i], a);
            ack = ack & a;
        end
        stop();
    endtask

    task automatic rd_regs(input logic [6:0] addr, input logic [7:0] idx, input int n, output logic [7:0] q[$],
                           output logic ack);
        logic a;
        logic s;
        logic [7:0] d;
        start();
        send8({addr, 1'b0}, ack);
        send8(idx, a);
        ack = ack & a;
        start();
        send8({addr, 1'b1}, a);
        ack = ack & a;
        q = {};
        for (int k = 0; k < n; k++) begin
            for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
            // not-acknowledge on the last byte ends the read
            bit_io(k == n - 1, s);
            q.push_back(d);
        end
        stop();
    endtask
endmodule

// ---- tb_top.sv ----
// self-checking testbench for the codec power-up register bank
`timescale 1ns/10ps
module tb_top
    import cpr_pkg::*;
;
    localparam int FS_PER = 400;
    localparam int MCLK_CYC = 40;
    localparam int FAST_PER = 120;
    localparam logic [6:0] ADDR = CPR_DEV_ADDR_DEF;

    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic sel_pin = 1'b0;
    logic crst = 1'b0;
    logic scl, sda_low, mclk, fs, sda_line, sda_o, sda_oe;
    logic regs_ready, pu_mode, conv_run, sample_stb, rate_err;
    logic [3:0] word_bits;
    logic [15:0] mpf;
    cpr_regs_t regs;
    int n_errors = 0;
    int n_tests = 0;

    always #2 clk = ~clk;

    // open-drain data line with pull-up
    assign sda_line = ~(sda_low | (sda_oe & ~sda_o));

    cpr_host_model cpr_host_model_inst (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low),
        .mclk(mclk), .fs(fs));

    cpr_codec_regs #(.MIN_FRAME_CYC(200)) cpr_codec_regs_inst (.clk(clk), .nrst(nrst),
        .power_up_select_pin(sel_pin), .codec_reset_cmd(crst), .master_clk_in(mclk), .frame_sync_input(fs),
        .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .regs_o(regs), .regs_ready(regs_ready),
        .power_up_mode(pu_mode), .conv_run(conv_run), .word_bits(word_bits), .sample_stb(sample_stb),
        .mclk_per_frame(mpf), .frame_rate_err(rate_err));

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    function automatic cpr_regs_t dflt(input logic sel);
        return {8'h00, 8'h00, 8'h00, 8'ha0, 8'h40, 8'h02, sel ? 8'h9b : 8'hf6};
    endfunction

    task automatic chk_regs(input logic sel);
        cpr_regs_t e;
        e = dflt(sel);
        for (int i = 0; i < CPR_NUM_REGS; i++) chk_val({8'h00, regs[i*8 +: 8]}, {8'h00, e[i*8 +: 8]}, "reg default");
    endtask

    task automatic sc_power_on(input logic sel);
        int k;
        nrst = 1'b0;
        sel_pin = sel;
        tick(5);
        nrst = 1'b1;
        k = 0;
        while (regs_ready !== 1'b1 && k < 50) begin
            tick(1);
            k++;
        end
        chk_flag(k < 50, 1'b1, "ready after reset");
        chk_regs(sel);
        chk_flag(pu_mode, sel, "power-up mode");
        chk_flag(conv_run, sel, "conversion running");
        chk_val({12'h000, word_bits}, 16'h000f, "sample word width");
    endtask

    task automatic sc_read_all();
        logic [7:0] q[$];
        logic ack;
        cpr_regs_t e;
        e = dflt(1'b1);
        cpr_host_model_inst.rd_regs(ADDR, 8'h00, 8, q, ack);
        chk_flag(ack, 1'b1, "read acknowledged");
        for (int i = 0; i < CPR_NUM_REGS; i++) chk_val({8'h00, q[i]}, {8'h00, e[i*8 +: 8]}, "read back default");
        chk_val({8'h00, q[7]}, 16'h0000, "read past last register");
    endtask

    task automatic sc_write_refuse();
        logic [7:0] q[$];
        logic ack;
        cpr_host_model_inst.wr_regs(ADDR, 8'h04, {8'ha5, 8'h3c}, ack);
        chk_flag(ack, 1'b1, "write acknowledged");
        chk_val({8'h00, regs.high_tone}, 16'h00a5, "high tone written");
        chk_val({8'h00, regs.low_tone}, 16'h003c, "low tone auto increment");
        chk_flag(conv_run, 1'b1, "host write starts conversion");
        cpr_host_model_inst.rd_regs(ADDR, 8'h04, 2, q, ack);
        chk_val({8'h00, q[0]}, 16'h00a5, "high tone read back");
        chk_val({8'h00, q[1]}, 16'h003c, "low tone read back");
        cpr_host_model_inst.wr_regs(ADDR, 8'h07, {8'h77}, ack);
        chk_flag(ack, 1'b1, "write past last register acked");
        chk_val({8'h00, regs.aux}, 16'h0000, "auxiliary untouched");
        cpr_host_model_inst.wr_regs(ADDR ^ 7'h01, 8'h06, {8'h66}, ack);
        chk_flag(ack, 1'b0, "foreign address refused");
        chk_val({8'h00, regs.aux}, 16'h0000, "foreign write ignored");
        cpr_host_model_inst.wr_regs(ADDR, 8'h01, {8'h0a}, ack);
        chk_val({12'h000, word_bits}, 16'h0008, "companded word width");
    endtask

    task automatic sc_frames();
        int n;
        cpr_host_model_inst.fs_per = FS_PER;
        tick(2 * FS_PER);
        n = 0;
        for (int i = 0; i < 10 * FS_PER; i++) begin
            tick(1);
            if (sample_stb === 1'b1) n++;
        end
        chk_val(n[15:0], 16'h000a, "strobes per ten frames");
        chk_val(mpf, 16'(FS_PER / MCLK_CYC), "master clocks per frame");
        chk_flag(rate_err, 1'b0, "legal frame rate");
        cpr_host_model_inst.fs_per = FAST_PER;
        tick(4 * FAST_PER);
        chk_flag(rate_err, 1'b1, "frame too fast");
        cpr_host_model_inst.fs_per = 0;
        tick(FS_PER);
    endtask

    task automatic sc_codec_reset(input logic sel);
        sel_pin = sel;
        tick(20);
        chk_flag(pu_mode, ~sel, "strap ignored outside reset");
        chk_val({8'h00, regs.power}, sel ? 16'h00f6 : 16'h009b, "power kept outside reset");
        crst = 1'b1;
        tick(8);
        crst = 1'b0;
        tick(8);
        chk_regs(sel);
        chk_flag(pu_mode, sel, "mode after codec reset");
        chk_flag(conv_run, sel, "conversion after codec reset");
        chk_flag(rate_err, 1'b0, "rate error cleared");
    endtask

    initial begin
        sc_power_on(1'b0);
        sc_write_refuse();
        sc_frames();
        sc_codec_reset(1'b1);
        sc_codec_reset(1'b0);
        sc_power_on(1'b1);
        sc_read_all();
        tally_and_finish();
    end

    // hang guard
    initial begin
        #400000;
        n_errors++;
        $display("MISMATCH at %0t: run did not complete", $time);
        tally_and_finish();
    end
endmodule
